// >>> verilog/inventory_slot_pkg.sv
// Purpose: Shared constants and types for the inventory slot logic.
// Assumes: Core clock at 40 MHz, carrier at 13.56 MHz.
// Notes: Delay counts are derived from carrier periods and clock rate.
package inventory_slot_pkg;

   // Clock and carrier rates in hertz
   localparam longint CLOCK_HZ = 40_000_000;
   localparam longint CARRIER_HZ = 13_560_000;

   // Reply delay in carrier periods, and its count in core cycles
   localparam longint REPLY_DELAY_PERIODS = 4352;
   localparam int REPLY_DELAY_CYCLES =
      int'(REPLY_DELAY_PERIODS * CLOCK_HZ / CARRIER_HZ);
   // Allowed timing deviation in carrier periods
   localparam longint TOLERANCE_PERIODS = 32;
   localparam int TOLERANCE_CYCLES =
      int'(TOLERANCE_PERIODS * CLOCK_HZ / CARRIER_HZ);
   localparam int DELAY_W = 16;

   // Identifier and mask geometry
   localparam int UID_W = 64;
   localparam int BYTE_W = 8;
   localparam int CRC_BYTES = 2;
   localparam logic [7:0] MAX_MASK_BITS = 8'h40;
   localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

   // Slot geometry for the two slot modes
   localparam logic [3:0] SLOT_LAST_MULTI = 4'hf;
   localparam logic [3:0] SLOT_LAST_SINGLE = 4'h0;
   localparam logic [7:0] SLOT_WIDTH_MULTI = 8'h04;
   localparam logic [7:0] SLOT_WIDTH_SINGLE = 8'h00;

   // Request flag bit positions and command code
   localparam int FLAG_SUBCARRIER = 0;
   localparam int FLAG_DATA_RATE = 1;
   localparam int FLAG_INVENTORY = 2;
   localparam int FLAG_EXTENSION = 3;
   localparam int FLAG_AFI = 4;
   localparam int FLAG_SINGLE_SLOT = 5;
   localparam int FLAG_OPTION = 6;
   localparam int FLAG_RFU = 7;
   localparam logic [7:0] CMD_INVENTORY = 8'h01;

   // Byte positions within the request
   localparam logic [7:0] POS_FLAGS = 8'h00;
   localparam logic [7:0] POS_CMD = 8'h01;
   localparam logic [7:0] POS_LEN_NO_AFI = 8'h02;

   // Core sequencing states
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_receive = 2'b01,
      st_delay = 2'b10,
      st_slot_wait = 2'b11
   } state_t;

endpackage : inventory_slot_pkg

// >>> verilog/inventory_anticollision_slots.sv
// Purpose: Tag-side anti-collision slot sequencing for inventory requests.
// Assumes: Link decoder gives sof, eof, bit and error pulses on link_clock.
// Notes: Byte and event crossing uses toggles; bytes arrive far apart.
`timescale 1ns/1ps

// Summary of operation
// R1 - Mask length counts significant bits; mask bytes are zero padded on top.
// R2 - Mask bits arrive least significant first and are assembled so.
// R3 - Slot zero begins at the request end-of-frame, no extra pulse.
// R4 - Each further reader end-of-frame advances to the next slot.
// R5 - Reader may advance a slot when no reply was heard.
// R6 - Reader waits for a full reply frame before advancing.
// R7 - Single-slot flag gives one slot, width zero; else sixteen, width four.
// R8 - Slot index starts at zero each inventory, ranges zero to fifteen.
// R9 - Reply only when low identifier bits equal slot index over mask.
// R10 - Start-of-frame while waiting abandons the sequence for the new request.
// R11 - End-of-frame increments slot only below last slot; then sequence ends.
// R12 - Any new inventory restarts slot numbering at zero.
// R13 - Reply or slot move waits nominally 4352 carrier periods after eof.
// R14 - Reader waits 4192 carrier periods after a reply before next frame.
// R15 - Reply delay upper bound does not apply to write-type requests.
// R16 - Inventory delays hold within plus or minus 32 carrier periods.
// R17 - Reader sends slot-advance pulses with ten percent modulation.
// R18 - Quiet tag ignores requests with the inventory flag set.
// R19 - Inventory request with frame errors gets no reply.
// R20 - Delays are clock counters reloaded at each accepted reader eof edge.
module inventory_anticollision_slots #(
   parameter int REPLY_DELAY_CYCLES = inventory_slot_pkg::REPLY_DELAY_CYCLES
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic link_clock,
   input wire logic link_sof,
   input wire logic link_eof,
   input wire logic link_bit,
   input wire logic link_bit_valid,
   input wire logic link_error,
   input wire logic quiet,
   input wire logic [inventory_slot_pkg::UID_W-1:0] uid,
   output logic reply_start,
   output logic sequence_abort,
   output logic anticollision_active,
   output logic [3:0] slot_index
);
   import inventory_slot_pkg::*;

   // Link domain
   logic link_rst_b_meta;
   logic link_rst_b;
   logic [BYTE_W-1:0] link_shift;
   logic [BYTE_W-1:0] link_byte;
   logic [2:0] link_bit_count;
   logic [3:0] link_tgl;
   logic link_byte_tgl;

   // Core domain
   logic [3:0] tgl_meta;
   logic [3:0] tgl_sync;
   logic [3:0] tgl_seen;
   logic sof_evt;
   logic eof_evt;
   logic byte_evt;
   logic err_evt;
   state_t state;
   logic frame_bad;
   logic [7:0] byte_count;
   logic [7:0] flags;
   logic [7:0] command;
   logic [7:0] mask_len;
   logic [UID_W-1:0] mask;
   logic single_slot_select;
   logic [DELAY_W-1:0] delay_count;
   logic [7:0] len_pos;
   logic [8:0] mask_bytes;
   logic [8:0] expect_bytes;
   logic [7:0] slot_index_width;
   logic [3:0] slot_last;
   logic [7:0] req_slot_width;
   logic flags_ok;
   logic req_ok;
   logic [UID_W-1:0] bit_ok;
   logic match_ok;
   logic reload;

   // Reset carried into link domain as a level
   always_ff @(posedge link_clock) begin
      link_rst_b_meta <= rst_b;
      link_rst_b <= link_rst_b_meta;
   end

   // R2 lsb-first assembly
   always_ff @(posedge link_clock) begin
      if (!link_rst_b) begin
         link_shift <= 8'h00;
         link_byte <= 8'h00;
         link_bit_count <= 3'h0;
         link_byte_tgl <= 1'b0;
      end else if (link_sof) begin
         link_bit_count <= 3'h0;
      end else if (link_bit_valid) begin
         link_shift <= {link_bit, link_shift[BYTE_W-1:1]};
         link_bit_count <= link_bit_count + 3'h1;
         if (link_bit_count == BYTE_LAST_BIT) begin
            link_byte <= {link_bit, link_shift[BYTE_W-1:1]};
            link_byte_tgl <= ~link_byte_tgl;
         end
      end
   end

   // Frame markers, byte and errors as toggles: 0 sof, 1 eof, 2 byte, 3 error
   always_ff @(posedge link_clock) begin
      if (!link_rst_b) begin
         link_tgl <= 4'h0;
      end else begin
         link_tgl <= {link_tgl[3] ^ link_error, link_byte_tgl, // Byte lags data
            link_tgl[1] ^ link_eof, link_tgl[0] ^ link_sof};
      end
   end

   // Toggle synchronisers and edge detect on the second stage
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         tgl_meta <= 4'h0;
         tgl_sync <= 4'h0;
         tgl_seen <= 4'h0;
      end else begin
         tgl_meta <= link_tgl;
         tgl_sync <= tgl_meta;
         tgl_seen <= tgl_sync;
      end
   end

   // Event pulses in the core domain
   assign sof_evt = tgl_sync[0] ^ tgl_seen[0];
   assign eof_evt = tgl_sync[1] ^ tgl_seen[1];
   assign byte_evt = tgl_sync[2] ^ tgl_seen[2];
   assign err_evt = tgl_sync[3] ^ tgl_seen[3];

   // Request field layout
   assign len_pos = flags[FLAG_AFI] ? POS_LEN_NO_AFI + 8'h01 : POS_LEN_NO_AFI;
   // R1 whole mask bytes
   assign mask_bytes = ({1'b0, mask_len} + 9'h007) >> 3;
   assign expect_bytes = {1'b0, len_pos} + 9'h001 + mask_bytes
      + 9'(CRC_BYTES);

   // R7 slot geometry
   assign slot_index_width = single_slot_select ? SLOT_WIDTH_SINGLE
      : SLOT_WIDTH_MULTI;
   assign slot_last = single_slot_select ? SLOT_LAST_SINGLE : SLOT_LAST_MULTI;
   assign req_slot_width = flags[FLAG_SINGLE_SLOT] ? SLOT_WIDTH_SINGLE
      : SLOT_WIDTH_MULTI;

   // Flag values the tag accepts
   assign flags_ok = !flags[FLAG_SUBCARRIER] && flags[FLAG_DATA_RATE]
      && flags[FLAG_INVENTORY] && !flags[FLAG_EXTENSION]
      && !flags[FLAG_OPTION] && !flags[FLAG_RFU];

   // R18 quiet ignores, R19 errors give silence
   assign req_ok = flags_ok && (command == CMD_INVENTORY) && !quiet
      && !frame_bad && !err_evt && ({1'b0, byte_count} == expect_bytes)
      && ({1'b0, mask_len} + {1'b0, req_slot_width}
      <= {1'b0, MAX_MASK_BITS});

   // R9 per-bit identifier comparison
   for (genvar i = 0; i < UID_W; i++) begin : g_cmp
      logic [7:0] off;
      assign off = 8'(i) - mask_len;
      assign bit_ok[i] = (8'(i) < mask_len) ? (uid[i] == mask[i])
         : ({1'b0, 8'(i)} < {1'b0, mask_len} + {1'b0, slot_index_width})
         ? (uid[i] == slot_index[off[1:0]]) : 1'b1;
   end
   assign match_ok = &bit_ok;

   // R20 reload on each accepted eof
   assign reload = (state == st_receive && eof_evt && req_ok && !sof_evt)
      || (state == st_slot_wait && eof_evt && !sof_evt
      && slot_index < slot_last);

   // Frame error latch, cleared by a new frame
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         frame_bad <= 1'b0;
      end else if (err_evt) begin
         frame_bad <= 1'b1;
      end else if (sof_evt) begin
         frame_bad <= 1'b0;
      end
   end

   // Request byte capture
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         byte_count <= 8'h00;
         flags <= 8'h00;
         command <= 8'h00;
         mask_len <= 8'h00;
         mask <= 64'h0000_0000_0000_0000;
      end else if (sof_evt) begin
         byte_count <= 8'h00;
         mask <= 64'h0000_0000_0000_0000;
      end else if (state == st_receive && byte_evt) begin
         if (byte_count != 8'hff) begin
            byte_count <= byte_count + 8'h01;
         end
         if (byte_count == POS_FLAGS) begin
            flags <= link_byte;
         end else if (byte_count == POS_CMD) begin
            command <= link_byte;
         end else if (byte_count == len_pos) begin
            mask_len <= link_byte;
         end else if (byte_count > len_pos
               && byte_count - len_pos <= 8'h08) begin
            // R2 first byte is least significant
            mask[(byte_count - len_pos - 8'h01) * 8 +: BYTE_W] <= link_byte;
         end
      end
   end

   // Sequencing state
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state <= st_idle;
      end else if (sof_evt) begin
         // R10 new frame abandons sequence
         state <= st_receive;
      end else begin
         unique case (state)
            st_idle: begin
               state <= st_idle;
            end
            st_receive: begin
               if (eof_evt) begin
                  // R3 slot zero starts here
                  state <= req_ok ? st_delay : st_idle;
               end
            end
            st_delay: begin
               if (delay_count == 16'h0001) begin
                  state <= st_slot_wait;
               end
            end
            st_slot_wait: begin
               if (eof_evt) begin
                  // R4 R11 advance or finish
                  state <= (slot_index < slot_last) ? st_delay : st_idle;
               end
            end
         endcase
      end
   end

   // R8 R12 slot index and mode capture
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         slot_index <= 4'h0;
         single_slot_select <= 1'b0;
      end else if (state == st_receive && eof_evt && req_ok) begin
         slot_index <= 4'h0;
         single_slot_select <= flags[FLAG_SINGLE_SLOT];
      end else if (state == st_slot_wait && reload) begin
         // R11 increment below last
         slot_index <= slot_index + 4'h1;
      end
   end

   // R13 R16 R20 delay counter
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         delay_count <= 16'h0000;
      end else if (reload) begin
         delay_count <= DELAY_W'(REPLY_DELAY_CYCLES);
      end else if (state == st_delay && delay_count != 16'h0000) begin
         delay_count <= delay_count - 16'h0001;
      end
   end

   // R9 R15 reply strobe at delay end
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         reply_start <= 1'b0;
      end else begin
         reply_start <= !sof_evt && state == st_delay
            && delay_count == 16'h0001 && match_ok;
      end
   end

   // Status outputs
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sequence_abort <= 1'b0;
         anticollision_active <= 1'b0;
      end else begin
         sequence_abort <= sof_evt
            && (state == st_slot_wait || state == st_delay);
         anticollision_active <= !sof_evt && (reload
            || (anticollision_active && !(state == st_slot_wait
            && eof_evt && slot_index >= slot_last)));
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   property p_slot_zero;
      state == st_receive && eof_evt && req_ok && !sof_evt
         |=> state == st_delay && slot_index == 4'h0;
   endproperty
   a_slot_zero: assert property (p_slot_zero) // R3
      else $error("slot zero not started at request eof");

   property p_advance;
      state == st_slot_wait && eof_evt && !sof_evt && slot_index < slot_last
         |=> state == st_delay && slot_index == $past(slot_index) + 4'h1;
   endproperty
   a_advance: assert property (p_advance) // R11
      else $error("slot did not advance on eof");

   property p_end;
      state == st_slot_wait && eof_evt && !sof_evt && slot_index == slot_last
         |=> state == st_idle ##1 !anticollision_active;
   endproperty
   a_end: assert property (p_end) // R11
      else $error("sequence did not end after last slot");

   property p_abandon;
      state == st_slot_wait && sof_evt
         |=> state == st_receive && sequence_abort;
   endproperty
   a_abandon: assert property (p_abandon) // R10
      else $error("start of frame did not abandon sequence");

   property p_delay_load;
      reload |=> delay_count == DELAY_W'(REPLY_DELAY_CYCLES)
         ##1 delay_count == DELAY_W'(REPLY_DELAY_CYCLES - 1);
   endproperty
   a_delay_load: assert property (p_delay_load) // R13
      else $error("reply delay not reloaded at eof");

   property p_reply;
      state == st_delay && delay_count == 16'h0001 && !sof_evt
         |=> reply_start == $past(match_ok) && state == st_slot_wait;
   endproperty
   a_reply: assert property (p_reply) // R9
      else $error("reply strobe disagrees with match");

   property p_quiet;
      state == st_receive && eof_evt && !sof_evt && quiet |=> state == st_idle;
   endproperty
   a_quiet: assert property (p_quiet) // R18
      else $error("quiet tag entered anti-collision");

   property p_error;
      state == st_receive && eof_evt && !sof_evt && frame_bad
         |=> state == st_idle ##1 !reply_start;
   endproperty
   a_error: assert property (p_error) // R19
      else $error("errored request was accepted");

   property p_single;
      state == st_slot_wait && eof_evt && !sof_evt && single_slot_select
         |=> state == st_idle;
   endproperty
   a_single: assert property (p_single) // R7
      else $error("single slot mode ran more than one slot");

endmodule : inventory_anticollision_slots

// >>> tb/reader_model.sv
// Purpose: Reader model that drives request frames and slot pulses.
// Assumes: Each event lasts one link clock; bytes go out low bit first.
// Notes: The data line shows the inverse bit between strobes.
`timescale 1ns/1ps
module reader_model #(
   parameter int GAP = 40,
   parameter int TURN = 100
) (
   input wire logic link_clock,
   output logic link_sof,
   output logic link_eof,
   output logic link_bit,
   output logic link_bit_valid,
   output logic link_error
);
   // Idle levels from time zero
   initial begin
      {link_sof, link_eof, link_error, link_bit_valid, link_bit} = 5'h00;
   end

   // One framing event, coded as {sof, eof, error}
   task automatic ev(input logic [2:0] k);
      @(negedge link_clock);
      {link_sof, link_eof, link_error} = k;
      @(negedge link_clock);
      {link_sof, link_eof, link_error} = 3'h0;
      repeat (GAP) @(negedge link_clock);
   endtask : ev

   task automatic send_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(negedge link_clock);
         link_bit = b[i];
         link_bit_valid = 1'b1;
         @(negedge link_clock);
         link_bit_valid = 1'b0;
         link_bit = ~b[i];
      end
      repeat (GAP) @(negedge link_clock);
   endtask : send_byte

   task automatic request(input logic one, input logic afi,
         input logic [7:0] len, input logic [15:0] mask, input logic err);
      int nb;
      nb = (len + 7) / 8;
      ev(3'h4);
      send_byte({2'h0, one, afi, 4'h6});
      send_byte(8'h01);
      if (afi) send_byte(8'h00);
      send_byte(len);
      for (int k = 0; k < nb; k++) send_byte(mask[8*k +: 8]);
      send_byte(8'ha5);
      send_byte(8'h5a);
      if (err) ev(3'h1);
      ev(3'h2);
   endtask : request

   task automatic advance();
      repeat (TURN) @(negedge link_clock);
      ev(3'h2); // same slot pulse whatever the request
   endtask : advance
endmodule : reader_model

// >>> tb/inventory_anticollision_slots_tb.sv
// Purpose: Self-checking bench for the inventory slot sequencer.
// Assumes: Shortened reply delay; reader model drives the link side.
// Notes: Identifier low bits match an 11-bit mask in slot two.
`timescale 1ns/1ps
module inventory_anticollision_slots_tb;
   import inventory_slot_pkg::*;
   localparam int RD = 20;
   logic clock = 1'b0;
   logic link_clock = 1'b0;
   logic rst_b = 1'b0;
   logic quiet = 1'b0;
   logic [UID_W-1:0] uid = 64'h1234_5678_9abc_14cf;
   logic link_sof, link_eof, link_bit, link_bit_valid, link_error;
   logic reply_start, sequence_abort, anticollision_active;
   logic [3:0] slot_index;
   int cyc = 0;
   int eof_cyc = 0;
   int rep_cyc = 0;
   int replies = 0;
   int aborts = 0;
   int miscompares = 0;
   int cmp_count = 0;

   // Core and link clocks
   always #12.5 clock = ~clock;
   always #3 link_clock = ~link_clock;

   reader_model rdr (.link_clock(link_clock), .link_sof(link_sof),
      .link_eof(link_eof), .link_bit(link_bit),
      .link_bit_valid(link_bit_valid), .link_error(link_error));

   inventory_anticollision_slots #(.REPLY_DELAY_CYCLES(RD)) uut (
      .clock(clock), .rst_b(rst_b), .link_clock(link_clock),
      .link_sof(link_sof), .link_eof(link_eof), .link_bit(link_bit),
      .link_bit_valid(link_bit_valid), .link_error(link_error),
      .quiet(quiet), .uid(uid), .reply_start(reply_start),
      .sequence_abort(sequence_abort),
      .anticollision_active(anticollision_active),
      .slot_index(slot_index));

   // Cycle count and pulse monitors, off the launching edge
   always @(negedge clock) begin
      cyc++;
      if (reply_start === 1'b1) begin
         replies++;
         rep_cyc = cyc;
      end
      if (sequence_abort === 1'b1) aborts++;
   end
   always @(posedge link_eof) eof_cyc = cyc;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_in(input int v, input int lo, input int hi);
      cmp_count++;
      if (v < lo || v > hi) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
      end
   endtask : chk_in

   // Waits out one slot and judges reply, index and delay
   task automatic check_slot(input logic exp, input logic [3:0] s);
      int n0;
      n0 = replies;
      repeat (RD + 12) @(negedge clock);
      chk(16'(replies - n0), {15'h0, exp});
      chk({12'h0, slot_index}, {12'h0, s});
      chk({15'h0, anticollision_active}, 16'h1);
      if (exp) chk_in(rep_cyc - eof_cyc, RD + 2, RD + 7);
   endtask : check_slot

   // Expects silence and no running sequence
   task automatic check_none();
      int n0;
      n0 = replies;
      repeat (RD + 12) @(negedge clock);
      chk(16'(replies - n0), 16'h0);
      chk({15'h0, anticollision_active}, 16'h0);
   endtask : check_none

   task automatic sc_sixteen();
      rdr.request(1'b0, 1'b0, 8'h0b, 16'h04cf, 1'b0);
      check_slot(1'b0, 4'h0);
      for (int s = 1; s < 16; s++) begin
         rdr.advance();
         check_slot(s == 2, 4'(s));
      end
      rdr.advance();
      check_none();
   endtask : sc_sixteen

   task automatic sc_single();
      rdr.request(1'b1, 1'b0, 8'h08, 16'h00cf, 1'b0);
      check_slot(1'b1, 4'h0);
      rdr.advance();
      check_none();
   endtask : sc_single

   task automatic sc_abort();
      int n;
      rdr.request(1'b0, 1'b0, 8'h0b, 16'h04cf, 1'b0);
      check_slot(1'b0, 4'h0);
      rdr.advance();
      check_slot(1'b0, 4'h1);
      n = aborts;
      rdr.request(1'b0, 1'b1, 8'h0b, 16'h04cf, 1'b0);
      chk(16'(aborts - n), 16'h1);
      check_slot(1'b0, 4'h0);
      rdr.advance();
      check_slot(1'b0, 4'h1);
      rdr.advance();
      check_slot(1'b1, 4'h2);
   endtask : sc_abort

   task automatic sc_refuse();
      @(negedge clock);
      quiet = 1'b1;
      rdr.request(1'b1, 1'b0, 8'h08, 16'h00cf, 1'b0);
      check_none();
      @(negedge clock);
      quiet = 1'b0;
      rdr.request(1'b1, 1'b0, 8'h08, 16'h00cf, 1'b1);
      check_none();
   endtask : sc_refuse

   task automatic stop_test();
      $display("Compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   // Main sequence after reset
   initial begin
      repeat (16) @(negedge clock);
      chk({11'h0, anticollision_active, slot_index}, 16'h0);
      rst_b = 1'b1;
      repeat (4) @(negedge clock);
      sc_sixteen();
      sc_single();
      sc_abort();
      sc_refuse();
      stop_test();
   end

   // Watchdog against a hang
   initial begin
      #500_000;
      miscompares++;
      stop_test();
   end
endmodule : inventory_anticollision_slots_tb
